// file: rtl/imc_mode_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// [RL1] Both converters run concurrently, finishing independently.
// [RL2] Combined conversion yields loss and frequency together.
// [RL3] High-resolution inductance result is 24 bits.
// [RL4] Combined conversion length set by response time.
// [RL5] High-resolution interval set by reference count only.
// [RL6] Interval spans 5.44 us to 65.54 ms; the code rounds the floor up to 218 cycles, 5.45 us.
// [RL7] Larger reference count gives finer inductance result.
// [RL8] Frequency found counting reference cycles per sensor.
// [RL9] Loss code derives from injected drive power.
// [RL10] Range register floor/ceiling currents scale loss.
// [RL11] Both inductance-only bits disable loss measurement.
// [RL12] Software sets time constants before loss use.
// [RL13] Rates capped at 156.25 and 183.8 ksps.
// [RL14] Enabled comparator drives switch level on pin.
// [RL15] Software reconfigures only while conversions sleep.
// [RL16] Result fields update together at completion.
module imc_mode_ctrl (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_active,
   input wire logic i_sensor_osc,
   input wire logic [7:0] i_inject_level,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [5:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic [2:0] o_range_floor,
   output logic [2:0] o_range_ceiling,
   output logic [7:0] o_time_const1,
   output logic [7:0] o_time_const2,
   output logic o_loss_enable,
   output logic o_interrupt_out,
   output logic o_interrupt_out_oe
);
   logic [7:0] range_reg;
   logic [7:0] tconst1_reg;
   logic [7:0] tconst2_reg;
   logic [7:0] resp_reg;
   logic [7:0] alt_reg;
   logic [7:0] cmp_ctrl_reg;
   logic [7:0] detect_reg;
   logic [15:0] thr_hi_reg;
   logic [15:0] thr_lo_reg;
   logic [15:0] hr_count_reg;
   logic [15:0] loss_reg;
   logic [15:0] freq_reg;
   logic [23:0] hr_res_reg;
   logic cmb_flag_reg;
   logic hr_flag_reg;
   logic [2:0] osc_sync_reg;
   logic sensor_edge;
   logic loss_en;
   logic cmb_done;
   logic hr_done;
   logic [15:0] cmb_freq;
   logic [25:0] cmb_acc;
   logic [23:0] hr_result;
   logic [21:0] hr_interval;
   logic [15:0] loss_next;
   logic [7:0] rdata_next;
   logic [25:0] loss_scaled;

   // Stage 0 only feeds stage 1; the edge detector looks at stages 1 and 2.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         osc_sync_reg <= 3'h0;
      end else begin
         osc_sync_reg <= {osc_sync_reg[1:0], i_sensor_osc};
      end
   end
   assign sensor_edge = osc_sync_reg[1] && !osc_sync_reg[2];

   assign loss_en = !(alt_reg[imc_pkg::LONLY_BIT] && detect_reg[imc_pkg::LONLY_BIT]); // RL11

   // Interval is the minimum plus one step per reference count.
   assign hr_interval = 22'(imc_pkg::HR_MIN_CYC) +
      22'(hr_count_reg) * 22'(imc_pkg::HR_STEP_CYC); // RL6

   // Two independent engines share only the run enable and the sensor edge; no handshake ties them.
   imc_combined_conv imc_combined_conv_inst ( // RL1
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_run(i_active),
      .i_sensor_edge(sensor_edge),
      .i_inject_level(i_inject_level),
      .i_resp_sel(resp_reg[2:0]),
      .o_done(cmb_done),
      .o_freq(cmb_freq),
      .o_acc(cmb_acc)
   );

   imc_high_res_conv #(
      .RES_W(24)
   ) imc_high_res_conv_inst ( // RL1
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_run(i_active),
      .i_sensor_edge(sensor_edge),
      .i_interval(hr_interval),
      .o_done(hr_done),
      .o_result(hr_result)
   );

   // More injected power means a lossier resonator, so the code falls.
   assign loss_scaled = (cmb_acc << 8) >> (imc_pkg::CMB_BASE_LOG2 + int'(resp_reg[2:0]));
   assign loss_next = loss_en ? ~loss_scaled[15:0] : 16'h0000; // RL9 RL11

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         range_reg <= imc_pkg::RANGE_RST;
         tconst1_reg <= imc_pkg::TCONST_RST;
         tconst2_reg <= imc_pkg::TCONST_RST;
         resp_reg <= imc_pkg::RESP_RST;
         alt_reg <= imc_pkg::CFG_RST;
         cmp_ctrl_reg <= imc_pkg::CFG_RST;
         detect_reg <= imc_pkg::CFG_RST;
         thr_hi_reg <= imc_pkg::THR_RST;
         thr_lo_reg <= imc_pkg::THR_RST;
         hr_count_reg <= imc_pkg::HR_COUNT_RST;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            imc_pkg::RANGE_OFS: range_reg <= i_reg_wdata;
            imc_pkg::TCONST1_OFS: tconst1_reg <= i_reg_wdata;
            imc_pkg::TCONST2_OFS: tconst2_reg <= i_reg_wdata;
            imc_pkg::RESP_OFS: resp_reg <= i_reg_wdata;
            imc_pkg::ALT_OFS: alt_reg <= i_reg_wdata;
            imc_pkg::CMP_CTRL_OFS: cmp_ctrl_reg <= i_reg_wdata;
            imc_pkg::DETECT_OFS: detect_reg <= i_reg_wdata;
            imc_pkg::THR_HI_LO_OFS: thr_hi_reg[7:0] <= i_reg_wdata;
            imc_pkg::THR_HI_HI_OFS: thr_hi_reg[15:8] <= i_reg_wdata;
            imc_pkg::THR_LO_LO_OFS: thr_lo_reg[7:0] <= i_reg_wdata;
            imc_pkg::THR_LO_HI_OFS: thr_lo_reg[15:8] <= i_reg_wdata;
            imc_pkg::HR_COUNT_LO_OFS: hr_count_reg[7:0] <= i_reg_wdata; // RL6
            imc_pkg::HR_COUNT_HI_OFS: hr_count_reg[15:8] <= i_reg_wdata; // RL6
            default: ;
         endcase
      end
   end

   // Results land in one edge so a read never pairs fields of two conversions.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         loss_reg <= 16'h0000;
         freq_reg <= 16'h0000;
      end else if (cmb_done) begin // RL16 RL2
         loss_reg <= loss_next;
         freq_reg <= cmb_freq;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         hr_res_reg <= 24'h000000;
      end else if (hr_done) begin // RL16 RL3
         hr_res_reg <= hr_result;
      end
   end

   // Completion flags clear on read, but a completion in that cycle wins.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         cmb_flag_reg <= 1'b0;
         hr_flag_reg <= 1'b0;
      end else begin
         if (cmb_done) begin
            cmb_flag_reg <= 1'b1;
         end else if (i_reg_rd && i_reg_addr == imc_pkg::STATUS_OFS) begin
            cmb_flag_reg <= 1'b0;
         end
         if (hr_done) begin
            hr_flag_reg <= 1'b1;
         end else if (i_reg_rd && i_reg_addr == imc_pkg::HR_STATUS_OFS) begin
            hr_flag_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      unique case (i_reg_addr)
         imc_pkg::RANGE_OFS: rdata_next = range_reg;
         imc_pkg::TCONST1_OFS: rdata_next = tconst1_reg;
         imc_pkg::TCONST2_OFS: rdata_next = tconst2_reg;
         imc_pkg::RESP_OFS: rdata_next = resp_reg;
         imc_pkg::ALT_OFS: rdata_next = alt_reg;
         imc_pkg::CMP_CTRL_OFS: rdata_next = cmp_ctrl_reg;
         imc_pkg::DETECT_OFS: rdata_next = detect_reg;
         imc_pkg::THR_HI_LO_OFS: rdata_next = thr_hi_reg[7:0];
         imc_pkg::THR_HI_HI_OFS: rdata_next = thr_hi_reg[15:8];
         imc_pkg::THR_LO_LO_OFS: rdata_next = thr_lo_reg[7:0];
         imc_pkg::THR_LO_HI_OFS: rdata_next = thr_lo_reg[15:8];
         imc_pkg::STATUS_OFS: rdata_next = 8'(cmb_flag_reg) << imc_pkg::CMB_DONE_BIT;
         imc_pkg::LOSS_LO_OFS: rdata_next = loss_reg[7:0];
         imc_pkg::LOSS_HI_OFS: rdata_next = loss_reg[15:8];
         imc_pkg::FREQ_LO_OFS: rdata_next = freq_reg[7:0];
         imc_pkg::FREQ_HI_OFS: rdata_next = freq_reg[15:8];
         imc_pkg::HR_COUNT_LO_OFS: rdata_next = hr_count_reg[7:0];
         imc_pkg::HR_COUNT_HI_OFS: rdata_next = hr_count_reg[15:8];
         imc_pkg::HR_RES0_OFS: rdata_next = hr_res_reg[7:0];
         imc_pkg::HR_RES1_OFS: rdata_next = hr_res_reg[15:8];
         imc_pkg::HR_RES2_OFS: rdata_next = hr_res_reg[23:16];
         imc_pkg::HR_STATUS_OFS: rdata_next = 8'(hr_flag_reg) << imc_pkg::HR_DONE_BIT;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rdata_next;
      end
   end

   // The analog loop holds oscillation only once these are set by software.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_range_floor <= 3'h0;
         o_range_ceiling <= 3'h0;
         o_time_const1 <= 8'h00;
         o_time_const2 <= 8'h00;
         o_loss_enable <= 1'b0;
      end else begin
         o_range_floor <= range_reg[imc_pkg::FLOOR_LSB +: 3]; // RL10
         o_range_ceiling <= range_reg[imc_pkg::CEIL_LSB +: 3]; // RL10
         o_time_const1 <= tconst1_reg; // RL12
         o_time_const2 <= tconst2_reg; // RL12
         o_loss_enable <= loss_en; // RL11
      end
   end

   // Hysteresis keeps the switch from chattering near a single threshold.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_interrupt_out <= 1'b0;
         o_interrupt_out_oe <= 1'b0;
      end else begin
         o_interrupt_out_oe <= cmp_ctrl_reg[imc_pkg::CMP_EN_BIT]; // RL14
         if (!cmp_ctrl_reg[imc_pkg::CMP_EN_BIT]) begin
            o_interrupt_out <= 1'b0;
         end else if (loss_reg > thr_hi_reg) begin // RL14
            o_interrupt_out <= 1'b1;
         end else if (loss_reg < thr_lo_reg) begin
            o_interrupt_out <= 1'b0;
         end
      end
   end

   // Helper counters for the checks below.
   logic [21:0] hr_gap_reg;
   logic [15:0] cmb_gap_reg;
   logic hr_seen_reg;
   logic cmb_seen_reg;
   always_ff @(posedge i_core_clk) begin
      if (i_srst || !i_active || i_reg_wr) begin
         hr_gap_reg <= 22'h000000;
         cmb_gap_reg <= 16'h0000;
         hr_seen_reg <= 1'b0;
         cmb_seen_reg <= 1'b0;
      end else begin
         hr_gap_reg <= hr_done ? 22'h000001 : hr_gap_reg + 22'h000001;
         cmb_gap_reg <= cmb_done ? 16'h0001 :
            (cmb_gap_reg == 16'hffff ? cmb_gap_reg : cmb_gap_reg + 16'h0001);
         hr_seen_reg <= hr_seen_reg | hr_done;
         cmb_seen_reg <= cmb_seen_reg | cmb_done;
      end
   end

   sequence cmb_finish_s;
      cmb_done && !loss_en;
   endsequence

   sequence loss_zeroed_s;
      loss_reg == 16'h0000;
   endsequence

   loss_off_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL11
      cmb_finish_s |=> loss_zeroed_s)
      else $error("Loss result not cleared in inductance-only mode.");

   hr_interval_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL5
      (hr_done && hr_seen_reg) |-> hr_gap_reg == hr_interval)
      else $error("High-resolution interval does not match reference count.");

   cmb_rate_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL13
      (cmb_done && cmb_seen_reg) |-> cmb_gap_reg >= 16'(imc_pkg::CMB_MIN_CYC))
      else $error("Combined conversions closer than the least interval.");

   cmb_atomic_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL16
      ($changed(freq_reg) || $changed(loss_reg)) |-> $past(cmb_done))
      else $error("Combined result changed without a completion.");

   hr_atomic_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL16
      $changed(hr_res_reg) |-> $past(hr_done))
      else $error("High-resolution result changed without a completion.");

   range_out_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL10
      (i_reg_wr && i_reg_addr == imc_pkg::RANGE_OFS) |-> ##2
      o_range_floor == $past(i_reg_wdata[2:0], 2))
      else $error("Range floor current not taken from range register.");

   switch_high_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL14
      (cmp_ctrl_reg[imc_pkg::CMP_EN_BIT] && loss_reg > thr_hi_reg) |=>
      o_interrupt_out && o_interrupt_out_oe)
      else $error("Switch output not high above the upper threshold.");

   switch_off_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL14
      !cmp_ctrl_reg[imc_pkg::CMP_EN_BIT] |=> !o_interrupt_out && !o_interrupt_out_oe)
      else $error("Switch output driven while comparator disabled.");

   flag_set_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL3
      hr_done |=> hr_flag_reg)
      else $error("High-resolution completion flag lost on a completion.");

   cmb_flag_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // RL2
      cmb_done |=> cmb_flag_reg)
      else $error("Combined completion flag lost on a completion.");
endmodule

// file: rtl/imc_pkg.sv
package imc_pkg;
   // Register offsets.
   localparam logic [5:0] RANGE_OFS = 6'h01;
   localparam logic [5:0] TCONST1_OFS = 6'h02;
   localparam logic [5:0] TCONST2_OFS = 6'h03;
   localparam logic [5:0] RESP_OFS = 6'h04;
   localparam logic [5:0] ALT_OFS = 6'h05;
   localparam logic [5:0] CMP_CTRL_OFS = 6'h0a;
   localparam logic [5:0] DETECT_OFS = 6'h0c;
   localparam logic [5:0] THR_HI_LO_OFS = 6'h16;
   localparam logic [5:0] THR_HI_HI_OFS = 6'h17;
   localparam logic [5:0] THR_LO_LO_OFS = 6'h18;
   localparam logic [5:0] THR_LO_HI_OFS = 6'h19;
   localparam logic [5:0] STATUS_OFS = 6'h20;
   localparam logic [5:0] LOSS_LO_OFS = 6'h21;
   localparam logic [5:0] LOSS_HI_OFS = 6'h22;
   localparam logic [5:0] FREQ_LO_OFS = 6'h23;
   localparam logic [5:0] FREQ_HI_OFS = 6'h24;
   localparam logic [5:0] HR_COUNT_LO_OFS = 6'h30;
   localparam logic [5:0] HR_COUNT_HI_OFS = 6'h31;
   localparam logic [5:0] HR_RES0_OFS = 6'h38;
   localparam logic [5:0] HR_RES1_OFS = 6'h39;
   localparam logic [5:0] HR_RES2_OFS = 6'h3a;
   localparam logic [5:0] HR_STATUS_OFS = 6'h3b;
   // Field positions.
   localparam int FLOOR_LSB = 0;
   localparam int CEIL_LSB = 4;
   localparam int LONLY_BIT = 0;
   localparam int CMP_EN_BIT = 0;
   localparam int CMB_DONE_BIT = 6;
   localparam int HR_DONE_BIT = 0;
   // Values after reset.
   localparam logic [7:0] RANGE_RST = 8'h07;
   localparam logic [7:0] TCONST_RST = 8'h00;
   localparam logic [7:0] RESP_RST = 8'h07;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [15:0] THR_RST = 16'h0000;
   localparam logic [15:0] HR_COUNT_RST = 16'hffff;
   // Timing: core clock period and interval limits.
   localparam int CLK_PERIOD_NS = 25;
   localparam int HR_STEP_NS = 1000;
   localparam int HR_MIN_NS = 5440;
   localparam int CMB_MIN_NS = 6400;
   localparam int HR_STEP_CYC = HR_STEP_NS / CLK_PERIOD_NS;
   // Floors round up so that neither engine can ever beat its rate ceiling.
   localparam int HR_MIN_CYC = (HR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CMB_MIN_CYC = (CMB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Log2 of sensor cycles per combined conversion at the shortest response time.
   localparam int CMB_BASE_LOG2 = 3;
endpackage

// file: rtl/imc_combined_conv.sv
`timescale 1ns/1ps
module imc_combined_conv #(
   parameter int MIN_CYC = imc_pkg::CMB_MIN_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_run,
   input wire logic i_sensor_edge,
   input wire logic [7:0] i_inject_level,
   input wire logic [2:0] i_resp_sel,
   output logic o_done,
   output logic [15:0] o_freq,
   output logic [25:0] o_acc
);
   logic [10:0] sens_cnt_reg;
   logic [15:0] ref_cnt_reg;
   logic [15:0] freq_cnt_reg;
   logic [25:0] acc_reg;
   logic [10:0] target;
   logic finish;

   // Longer response time means more sensor cycles, hence finer counts.
   assign target = 11'(11'h001 << (imc_pkg::CMB_BASE_LOG2 + int'(i_resp_sel))); // RL4
   // The rate ceiling is kept by never ending earlier than the least interval.
   assign finish = (sens_cnt_reg >= target) && (ref_cnt_reg >= 16'(MIN_CYC - 1)); // RL13

   always_ff @(posedge i_core_clk) begin
      if (i_srst || !i_run || finish) begin
         sens_cnt_reg <= 11'h000;
         ref_cnt_reg <= 16'h0000;
         freq_cnt_reg <= 16'h0000;
         acc_reg <= 26'h0000000;
      end else begin
         if (ref_cnt_reg != 16'hffff) begin // RL13
            ref_cnt_reg <= ref_cnt_reg + 16'h0001;
         end
         // Cycles from the first to the last counted sensor edge give the frequency.
         // The wait for the rate floor stays out of it, or it would hide the sensor.
         if (sens_cnt_reg != 11'h000 && sens_cnt_reg < target &&
               freq_cnt_reg != 16'hffff) begin // RL8
            freq_cnt_reg <= freq_cnt_reg + 16'h0001;
         end
         if (i_sensor_edge && sens_cnt_reg < target) begin
            sens_cnt_reg <= sens_cnt_reg + 11'h001;
            acc_reg <= acc_reg + 26'(i_inject_level); // RL9
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_done <= 1'b0;
         o_freq <= 16'h0000;
         o_acc <= 26'h0000000;
      end else begin
         o_done <= i_run && finish;
         if (i_run && finish) begin // RL2
            o_freq <= freq_cnt_reg;
            o_acc <= acc_reg;
         end
      end
   end
endmodule

// file: rtl/imc_high_res_conv.sv
`timescale 1ns/1ps
module imc_high_res_conv #(
   parameter int RES_W = 24
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_run,
   input wire logic i_sensor_edge,
   input wire logic [21:0] i_interval,
   output logic o_done,
   output logic [RES_W-1:0] o_result
);
   logic [21:0] tick_reg;
   logic [RES_W-1:0] edges_reg;
   logic finish;

   // The interval is counted in reference cycles only; the sensor never ends it.
   assign finish = (tick_reg >= i_interval - 22'h000001); // RL5

   always_ff @(posedge i_core_clk) begin
      if (i_srst || !i_run || finish) begin
         tick_reg <= 22'h000000;
         edges_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 22'h000001;
         // More reference counts let more sensor edges in, so the code grows finer.
         if (i_sensor_edge && edges_reg != '1) begin // RL7
            edges_reg <= edges_reg + RES_W'(1);
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_done <= 1'b0;
         o_result <= '0;
      end else begin
         o_done <= i_run && finish;
         if (i_run && finish) begin // RL3
            o_result <= edges_reg;
         end
      end
   end
endmodule

// file: sim/imc_sensor_model.sv
`timescale 1ns/1ps
// Free-running resonator with a fixed drive level set by the bench.
// A constant level trades realism for a loss code that the bench can predict.
module imc_sensor_model #(
   parameter int HALF_NS = 100
) (
   input wire logic i_core_clk,
   input wire logic [7:0] i_level,
   output logic o_osc,
   output logic [7:0] o_inject
);
   initial begin
      o_osc = 1'b0;
   end
   always #(HALF_NS) o_osc = ~o_osc;
   always_ff @(posedge i_core_clk) begin
      o_inject <= i_level;
   end
endmodule

// file: sim/inductive_measurement_mode_control_tb.sv
`timescale 1ns/1ps
`define IMC_CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module inductive_measurement_mode_control_tb;
   typedef struct packed {logic chk; logic [7:0] v;} imc_note_s;
   logic clk, srst, active, osc, wr, rd, rd_pend, loss_en, irq, irq_oe;
   logic [7:0] inject, level, wdata, rdata, tc1, tc2, v, v2;
   logic [5:0] addr;
   logic [2:0] floor_c, ceil_c;
   int mismatches = 0;
   int check_count = 0;
   int n;
   imc_note_s notes[$];
   imc_note_s nt;

   imc_sensor_model imc_sensor_model_inst (.i_core_clk(clk), .i_level(level), .o_osc(osc),
      .o_inject(inject));
   imc_mode_ctrl imc_mode_ctrl_inst (.i_core_clk(clk), .i_srst(srst), .i_active(active),
      .i_sensor_osc(osc), .i_inject_level(inject), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_range_floor(floor_c),
      .o_range_ceiling(ceil_c), .o_time_const1(tc1), .o_time_const2(tc2),
      .o_loss_enable(loss_en), .o_interrupt_out(irq), .o_interrupt_out_oe(irq_oe));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Read data lands on the edge that takes the read, so it is judged at the next falling edge.
   always @(posedge clk) rd_pend <= rd;
   always @(negedge clk) begin
      if (rd_pend === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt.chk) `IMC_CHK(rdata, nt.v)
      end
   end

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic rd_raw(input logic [5:0] a, input logic c, input logic [7:0] e,
         output logic [7:0] r);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      notes.push_back({c, e});
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      r = rdata;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] r;
      rd_raw(a, 1'b1, e, r);
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Returns the number of reads needed before the flag showed set.
   task automatic poll(input logic [5:0] a, input int b, output int cnt);
      logic [7:0] r;
      cnt = 0;
      do begin
         rd_raw(a, 1'b0, 8'h00, r);
         cnt++;
      end while (r[b] !== 1'b1 && cnt < 300);
   endtask

   // Outputs follow a register write two edges after the write strobe.
   task automatic settle();
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic run_both(input logic [7:0] loss_hi, input logic [7:0] loss_lo);
      @(posedge clk);
      active <= 1'b1;
      poll(imc_pkg::HR_STATUS_OFS, imc_pkg::HR_DONE_BIT, n);
      `IMC_CHK((n >= 104 && n <= 116), 1'b1)
      poll(imc_pkg::STATUS_OFS, imc_pkg::CMB_DONE_BIT, n);
      `IMC_CHK((n < 300), 1'b1)
      rd_chk(imc_pkg::LOSS_LO_OFS, loss_lo);
      rd_chk(imc_pkg::LOSS_HI_OFS, loss_hi);
      // Seven sensor periods of eight core cycles lie between the first and eighth edge.
      rd_chk(imc_pkg::FREQ_LO_OFS, 8'h38);
      rd_chk(imc_pkg::FREQ_HI_OFS, 8'h00);
      rd_raw(imc_pkg::HR_RES0_OFS, 1'b0, 8'h00, v);
      `IMC_CHK((v >= 8'd24 && v <= 8'd30), 1'b1)
      rd_chk(imc_pkg::HR_RES1_OFS, 8'h00);
      rd_chk(imc_pkg::HR_RES2_OFS, 8'h00);
      // A second completion of each engine gives the interval and rate checks a gap.
      poll(imc_pkg::HR_STATUS_OFS, imc_pkg::HR_DONE_BIT, n);
      `IMC_CHK((n < 300), 1'b1)
      poll(imc_pkg::STATUS_OFS, imc_pkg::CMB_DONE_BIT, n);
      `IMC_CHK((n < 300), 1'b1)
      @(posedge clk);
      active <= 1'b0;
   endtask

   initial begin
      srst = 1'b1;
      active = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 6'h00;
      wdata = 8'h00;
      level = 8'h00;
      void'($urandom(32'h9cbe));
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd_chk(imc_pkg::RANGE_OFS, 8'h07);
      rd_chk(imc_pkg::RESP_OFS, 8'h07);
      rd_chk(imc_pkg::HR_COUNT_LO_OFS, 8'hff);
      rd_chk(imc_pkg::HR_COUNT_HI_OFS, 8'hff);
      rd_chk(imc_pkg::ALT_OFS, 8'h00);
      rd_chk(6'h3f, 8'h00);
      `IMC_CHK(floor_c, 3'h7)
      `IMC_CHK(ceil_c, 3'h0)
      `IMC_CHK(loss_en, 1'b1)
      // Everything below is configured with conversions asleep.
      v = 8'($urandom());
      wr_reg(imc_pkg::RANGE_OFS, v);
      settle();
      `IMC_CHK(floor_c, v[2:0])
      `IMC_CHK(ceil_c, v[6:4])
      rd_chk(imc_pkg::RANGE_OFS, v);
      v = 8'($urandom());
      v2 = 8'($urandom());
      wr_reg(imc_pkg::TCONST1_OFS, v);
      wr_reg(imc_pkg::TCONST2_OFS, v2);
      settle();
      `IMC_CHK(tc1, v)
      `IMC_CHK(tc2, v2)
      wr_reg(imc_pkg::ALT_OFS, 8'h01);
      settle();
      `IMC_CHK(loss_en, 1'b1)
      wr_reg(imc_pkg::DETECT_OFS, 8'h01);
      settle();
      `IMC_CHK(loss_en, 1'b0)
      wr_reg(imc_pkg::HR_COUNT_LO_OFS, 8'h00);
      wr_reg(imc_pkg::HR_COUNT_HI_OFS, 8'h00);
      wr_reg(imc_pkg::RESP_OFS, 8'h00);
      wr_reg(imc_pkg::CMP_CTRL_OFS, 8'h01);
      level <= 8'($urandom());
      run_both(8'h00, 8'h00);
      // A zero loss code never rises above a zero upper threshold.
      `IMC_CHK(irq, 1'b0)
      wr_reg(imc_pkg::ALT_OFS, 8'h00);
      wr_reg(imc_pkg::DETECT_OFS, 8'h00);
      settle();
      `IMC_CHK(loss_en, 1'b1)
      // A zero drive level makes the loss code all ones whatever the edge count.
      level <= 8'h00;
      run_both(8'hff, 8'hff);
      rd_raw(imc_pkg::STATUS_OFS, 1'b0, 8'h00, v);
      `IMC_CHK(v[imc_pkg::CMB_DONE_BIT], 1'b0)
      `IMC_CHK(irq, 1'b1)
      `IMC_CHK(irq_oe, 1'b1)
      end_sim();
   end

   initial begin
      #(25 * 40000);
      mismatches++;
      end_sim();
   end
endmodule
